//--- pkg/tmr2_pkg.sv
// Package: register map, field layout and constants of the compare-timer block
package tmr2_pkg;

   // ----------------------------------------------------------------
   // Address map (data-space offsets)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h37;
   localparam logic [7:0] ADDR_IRQ_ENABLES = 8'h70;
   localparam logic [7:0] ADDR_CONTROL_FIRST = 8'hb0;
   localparam logic [7:0] ADDR_CONTROL_SECOND = 8'hb1;
   localparam logic [7:0] ADDR_COUNT_VALUE = 8'hb2;
   localparam logic [7:0] ADDR_COMPARE_A = 8'hb3;
   localparam logic [7:0] ADDR_COMPARE_B = 8'hb4;
   localparam logic [7:0] IO_SPACE_OFFSET = 8'h20;
   localparam logic [7:0] IO_SPACE_LAST = 8'h3f;
   localparam logic [7:0] EXT_IO_FIRST = 8'h60;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int BIT_FORCE_A = 7;
   localparam int BIT_FORCE_B = 6;
   localparam int BIT_WAVE_HIGH = 3;
   localparam int BIT_MATCH_B = 2;
   localparam int BIT_MATCH_A = 1;
   localparam int BIT_WRAP = 0;
   localparam logic [7:0] RESET_VALUE = 8'h00;
   localparam logic [7:0] COUNT_MAX = 8'hff;
   localparam logic [7:0] COUNT_BOTTOM = 8'h00;

   // Prescale terminal counts minus one for selects 2..7
   localparam logic [9:0] DIV_8 = 10'h007;
   localparam logic [9:0] DIV_32 = 10'h01f;
   localparam logic [9:0] DIV_64 = 10'h03f;
   localparam logic [9:0] DIV_128 = 10'h07f;
   localparam logic [9:0] DIV_256 = 10'h0ff;
   localparam logic [9:0] DIV_1024 = 10'h3ff;

   // Waveform modes (3-bit field)
   localparam logic [2:0] MODE_NORMAL = 3'h0;
   localparam logic [2:0] MODE_PC_FULL = 3'h1;
   localparam logic [2:0] MODE_CLEAR_ON_MATCH = 3'h2;
   localparam logic [2:0] MODE_FAST_FULL = 3'h3;
   localparam logic [2:0] MODE_PC_TOP_A = 3'h5;
   localparam logic [2:0] MODE_FAST_TOP_A = 3'h7;

   // Output actions in non-PWM modes
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_TOGGLE = 2'h1;
   localparam logic [1:0] ACT_CLEAR = 2'h2;
   localparam logic [1:0] ACT_SET = 2'h3;

   // Register bus request
   typedef struct packed {
      logic rd;
      logic wr;
      logic io_space;
      logic [7:0] addr;
      logic [7:0] wdata;
   } tmr2_req_t;

   // Complete block state
   typedef struct packed {
      logic [7:0] count;
      logic [7:0] cmp_a;
      logic [7:0] cmp_b;
      logic [1:0] act_a;
      logic [1:0] act_b;
      logic [1:0] wave_low;
      logic wave_high;
      logic [2:0] clk_sel;
      logic [2:0] irq_en;
      logic [2:0] flags;
      logic [9:0] presc;
      logic block_match;
      logic wave_a;
      logic wave_b;
      logic up;
      logic [7:0] rdata;
      logic [2:0] irq_req;
   } tmr2_state_t;

endpackage

//--- rtl/tmr2_regs.sv
// Timer 2 compare-channel register slice: counter, prescaler, compares, flags
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// [R1] Force strobes act only in non-PWM modes
// [R2] Force strobe applies channel output action immediately
// [R3] Forced match sets no flag, never clears
// [R4] Force strobe bits always read zero
// [R5] Software writes zero strobes in PWM
// [R6] Clock select: stop, /1, /8../1024
// [R7] Count writable; write blocks next match
// [R8] Software avoids writing a running count
// [R9] Both compares continuously matched against count
// [R10] Match-B request: enable, global, flag
// [R11] Match-A request: enable, global, flag
// [R12] Wrap request: enable, global, flag
// [R13] Short I/O address is offset minus 0x20
// [R14] Extended registers reachable by data space only
// [R15] Flags at I/O 0x17 and data 0x37
// [R16] Flags set by events, cleared by vector/one
// [R17] Normal and clear-on-match are non-PWM
// [R18] Count advances one per tick, holds stopped
module tmr2_regs
   import tmr2_pkg::*;
(
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   // Register port
   input wire logic REG_RD,
   input wire logic REG_WR,
   input wire logic REG_IO_SPACE,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   output logic [7:0] REG_RDATA,
   // Interrupt handshake with the core
   input wire logic GLOBAL_IRQ_EN,
   input wire logic [2:0] VECTOR_ACK,
   output logic [2:0] IRQ_REQ,
   // Waveform pins
   output logic WAVE_OUT_A,
   output logic WAVE_OUT_B
);

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   function automatic logic is_pwm(input logic [2:0] mode);
      is_pwm = !(mode == MODE_NORMAL || mode == MODE_CLEAR_ON_MATCH); // [R17]
   endfunction

   // Maps a request to its data-space offset; short I/O adds 0x20
   function automatic logic [8:0] data_addr(input tmr2_req_t rq);
      if (rq.io_space) begin
         if (rq.addr <= IO_SPACE_LAST) begin
            data_addr = {1'b0, rq.addr + IO_SPACE_OFFSET}; // [R13]
         end else begin
            data_addr = 9'h100;
         end
      end else begin
         data_addr = {1'b0, rq.addr};
      end
   endfunction

   tmr2_state_t s_r;
   tmr2_state_t s_nxt;
   tmr2_req_t req;
   logic [8:0] da;
   logic tick;
   logic [9:0] term;
   logic [2:0] mode;
   logic [7:0] top;
   logic hit_a;
   logic hit_b;
   logic wrap;
   logic force_a;
   logic force_b;
   logic ext_ok;
   logic wr_count;

   assign req = '{rd: REG_RD, wr: REG_WR, io_space: REG_IO_SPACE, addr: REG_ADDR,
                  wdata: REG_WDATA};

   always_comb begin
      s_nxt = s_r;
      da = data_addr(req);
      mode = {s_r.wave_high, s_r.wave_low};
      // Extended space is refused over short I/O
      ext_ok = !req.io_space || (da < {1'b0, EXT_IO_FIRST}); // [R14]
      wr_count = req.wr && ext_ok && da == {1'b0, ADDR_COUNT_VALUE};

      // --------------------------------------------------------------
      // Prescaler
      // --------------------------------------------------------------
      case (s_r.clk_sel) // [R6]
         3'h2: term = DIV_8;
         3'h3: term = DIV_32;
         3'h4: term = DIV_64;
         3'h5: term = DIV_128;
         3'h6: term = DIV_256;
         3'h7: term = DIV_1024;
         default: term = 10'h000;
      endcase
      if (s_r.clk_sel == 3'h0) begin
         tick = 1'b0;
         s_nxt.presc = 10'h000;
      end else if (s_r.presc >= term) begin
         tick = 1'b1;
         s_nxt.presc = 10'h000;
      end else begin
         tick = 1'b0;
         s_nxt.presc = s_r.presc + 10'h001;
      end

      // --------------------------------------------------------------
      // Counter and matches
      // --------------------------------------------------------------
      case (mode)
         MODE_CLEAR_ON_MATCH, MODE_PC_TOP_A, MODE_FAST_TOP_A: top = s_r.cmp_a;
         default: top = COUNT_MAX;
      endcase
      hit_a = tick && !s_r.block_match && s_r.count == s_r.cmp_a; // [R9]
      hit_b = tick && !s_r.block_match && s_r.count == s_r.cmp_b; // [R9]
      wrap = 1'b0;
      if (tick) begin
         s_nxt.block_match = 1'b0;
         case (mode)
            MODE_PC_FULL, MODE_PC_TOP_A: begin
               if (s_r.up) begin
                  if (s_r.count == top) begin
                     s_nxt.up = 1'b0;
                     s_nxt.count = s_r.count - 8'h01;
                  end else begin
                     s_nxt.count = s_r.count + 8'h01;
                  end
               end else if (s_r.count == COUNT_BOTTOM) begin
                  wrap = 1'b1;
                  s_nxt.up = 1'b1;
                  s_nxt.count = s_r.count + 8'h01;
               end else begin
                  s_nxt.count = s_r.count - 8'h01;
               end
            end
            default: begin
               s_nxt.up = 1'b1;
               if (s_r.count == top) begin
                  wrap = (mode != MODE_CLEAR_ON_MATCH) || (top == COUNT_MAX);
                  s_nxt.count = COUNT_BOTTOM;
               end else begin
                  s_nxt.count = s_r.count + 8'h01; // [R18]
               end
            end
         endcase
      end

      // --------------------------------------------------------------
      // Waveform outputs (non-PWM action table; PWM set/clear simplified)
      // --------------------------------------------------------------
      force_a = 1'b0;
      force_b = 1'b0;
      if (req.wr && ext_ok && da == {1'b0, ADDR_CONTROL_SECOND} && !is_pwm(mode)) begin // [R1]
         force_a = req.wdata[BIT_FORCE_A];
         force_b = req.wdata[BIT_FORCE_B];
      end
      // Forced matches only steer the pin, never the flags or counter
      if (hit_a || force_a) begin // [R2] [R3]
         case (s_r.act_a)
            ACT_TOGGLE: s_nxt.wave_a = !s_r.wave_a;
            ACT_CLEAR: s_nxt.wave_a = s_r.up ? 1'b0 : 1'b1;
            ACT_SET: s_nxt.wave_a = s_r.up ? 1'b1 : 1'b0;
            default: s_nxt.wave_a = s_r.wave_a;
         endcase
      end
      if (hit_b || force_b) begin // [R2] [R3]
         case (s_r.act_b)
            ACT_TOGGLE: s_nxt.wave_b = !s_r.wave_b;
            ACT_CLEAR: s_nxt.wave_b = s_r.up ? 1'b0 : 1'b1;
            ACT_SET: s_nxt.wave_b = s_r.up ? 1'b1 : 1'b0;
            default: s_nxt.wave_b = s_r.wave_b;
         endcase
      end

      // --------------------------------------------------------------
      // Register writes
      // --------------------------------------------------------------
      s_nxt.flags = s_r.flags & ~VECTOR_ACK; // [R16]
      if (req.wr && ext_ok) begin
         case (da)
            {1'b0, ADDR_EVENT_FLAGS}: s_nxt.flags = s_nxt.flags & ~req.wdata[2:0]; // [R15] [R16]
            {1'b0, ADDR_IRQ_ENABLES}: s_nxt.irq_en = req.wdata[2:0];
            {1'b0, ADDR_CONTROL_FIRST}: begin
               s_nxt.act_a = req.wdata[7:6];
               s_nxt.act_b = req.wdata[5:4];
               s_nxt.wave_low = req.wdata[1:0];
            end
            {1'b0, ADDR_CONTROL_SECOND}: begin
               s_nxt.wave_high = req.wdata[BIT_WAVE_HIGH];
               s_nxt.clk_sel = req.wdata[2:0];
            end
            {1'b0, ADDR_COUNT_VALUE}: s_nxt.count = req.wdata;
            {1'b0, ADDR_COMPARE_A}: s_nxt.cmp_a = req.wdata;
            {1'b0, ADDR_COMPARE_B}: s_nxt.cmp_b = req.wdata;
            default: s_nxt.flags = s_nxt.flags;
         endcase
      end
      // A count write suppresses the match on the next tick
      if (wr_count) begin // [R7]
         s_nxt.block_match = 1'b1;
      end
      // Hardware set wins over a simultaneous clear
      if (hit_b) begin
         s_nxt.flags[BIT_MATCH_B] = 1'b1; // [R16]
      end
      if (hit_a) begin
         s_nxt.flags[BIT_MATCH_A] = 1'b1; // [R16]
      end
      if (wrap) begin
         s_nxt.flags[BIT_WRAP] = 1'b1; // [R16]
      end

      // --------------------------------------------------------------
      // Read data and interrupt requests
      // --------------------------------------------------------------
      s_nxt.rdata = RESET_VALUE;
      if (req.rd && ext_ok) begin
         case (da)
            {1'b0, ADDR_EVENT_FLAGS}: s_nxt.rdata = {5'h00, s_r.flags}; // [R15]
            {1'b0, ADDR_IRQ_ENABLES}: s_nxt.rdata = {5'h00, s_r.irq_en};
            {1'b0, ADDR_CONTROL_FIRST}:
               s_nxt.rdata = {s_r.act_a, s_r.act_b, 2'h0, s_r.wave_low};
            {1'b0, ADDR_CONTROL_SECOND}:
               s_nxt.rdata = {2'h0, 2'h0, s_r.wave_high, s_r.clk_sel}; // [R4]
            {1'b0, ADDR_COUNT_VALUE}: s_nxt.rdata = s_r.count; // [R7]
            {1'b0, ADDR_COMPARE_A}: s_nxt.rdata = s_r.cmp_a;
            {1'b0, ADDR_COMPARE_B}: s_nxt.rdata = s_r.cmp_b;
            default: s_nxt.rdata = RESET_VALUE;
         endcase
      end
      s_nxt.irq_req[BIT_MATCH_B] = GLOBAL_IRQ_EN && s_r.irq_en[BIT_MATCH_B]
                                   && s_r.flags[BIT_MATCH_B]; // [R10]
      s_nxt.irq_req[BIT_MATCH_A] = GLOBAL_IRQ_EN && s_r.irq_en[BIT_MATCH_A]
                                   && s_r.flags[BIT_MATCH_A]; // [R11]
      s_nxt.irq_req[BIT_WRAP] = GLOBAL_IRQ_EN && s_r.irq_en[BIT_WRAP]
                                && s_r.flags[BIT_WRAP]; // [R12]
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         s_r <= '0;
         s_r.up <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign REG_RDATA = s_r.rdata;
   assign IRQ_REQ = s_r.irq_req;
   assign WAVE_OUT_A = s_r.wave_a;
   assign WAVE_OUT_B = s_r.wave_b;

endmodule

`default_nettype wire

//--- tb/test_tmr2_regs.sv
// Self-checking bench for the compare-timer register slice
`timescale 1ns/1ps
`default_nettype none
module test_tmr2_regs
   import tmr2_pkg::*;
;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   tmr2_req_t req = '0;
   logic global_irq_en = 1'b0;
   logic [2:0] vector_ack = 3'h0;
   logic [7:0] rdata;
   logic [2:0] irq_req;
   logic wave_a;
   logic wave_b;
   int n_errors = 0;
   int checks_done = 0;
   int divs [7] = '{1, 8, 32, 64, 128, 256, 1024};
   logic [2:0] pwm [4] = '{3'h1, 3'h3, 3'h5, 3'h7};
   logic [7:0] regs [5] = '{ADDR_EVENT_FLAGS, ADDR_IRQ_ENABLES, ADDR_COUNT_VALUE,
      ADDR_COMPARE_A, ADDR_COMPARE_B};
   always #2.5 sys_clk = ~sys_clk;
   tmr2_regs DUT (.SYS_CLK(sys_clk), .RESET_N(reset_n), .REG_RD(req.rd), .REG_WR(req.wr),
      .REG_IO_SPACE(req.io_space), .REG_ADDR(req.addr), .REG_WDATA(req.wdata),
      .REG_RDATA(rdata), .GLOBAL_IRQ_EN(global_irq_en), .VECTOR_ACK(vector_ack),
      .IRQ_REQ(irq_req), .WAVE_OUT_A(wave_a), .WAVE_OUT_B(wave_b));
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One-cycle request, launched just after an edge and dropped after the taking edge
   task automatic wr(input logic io, input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      #1 req = '{rd: 1'b0, wr: 1'b1, io_space: io, addr: a, wdata: d};
      @(posedge sys_clk);
      #1 req = '0;
   endtask
   task automatic rd(input logic io, input logic [7:0] a, input logic [7:0] exp, input string w);
      @(posedge sys_clk);
      #1 req = '{rd: 1'b1, wr: 1'b0, io_space: io, addr: a, wdata: 8'h00};
      @(posedge sys_clk);
      #1 req = '0;
      chk(w, exp, rdata);
   endtask
   // Runs the counter for exactly n edges, n of at least 2
   task automatic run(input logic [2:0] sel, input int n);
      wr(0, ADDR_CONTROL_SECOND, {5'h00, sel});
      repeat (n - 2) @(posedge sys_clk);
      wr(0, ADDR_CONTROL_SECOND, 8'h00);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge sys_clk);
      #1 reset_n = 1'b1;
      foreach (regs[i]) rd(0, regs[i], 8'h00, "reset value");
      $display("test reset values done");
      wr(0, ADDR_COMPARE_A, 8'ha5);
      wr(0, ADDR_COMPARE_B, 8'h5a);
      wr(0, ADDR_IRQ_ENABLES, 8'h07);
      rd(0, ADDR_COMPARE_A, 8'ha5, "compare a");
      rd(0, ADDR_COMPARE_B, 8'h5a, "compare b");
      rd(1, 8'h50, 8'h00, "short extended");
      wr(1, 8'h50, 8'h00);
      rd(0, ADDR_IRQ_ENABLES, 8'h07, "enables");
      rd(1, 8'h40, 8'h00, "short beyond");
      rd(0, 8'h71, 8'h00, "unmapped");
      $display("test access done");
      for (int s = 1; s < 8; s++) begin
         wr(0, ADDR_COUNT_VALUE, 8'h00);
         run(3'(s), 4 * divs[s - 1]);
         rd(0, ADDR_COUNT_VALUE, 8'h04, "ticks");
      end
      wr(0, ADDR_COUNT_VALUE, 8'h21);
      repeat (20) @(posedge sys_clk);
      rd(0, ADDR_COUNT_VALUE, 8'h21, "stopped count");
      $display("test prescale done");
      wr(0, ADDR_EVENT_FLAGS, 8'h07);
      wr(0, ADDR_CONTROL_FIRST, 8'h70);
      wr(0, ADDR_CONTROL_SECOND, 8'hc0);
      chk("pin a", 8'h01, {7'h00, wave_a});
      chk("pin b", 8'h01, {7'h00, wave_b});
      rd(0, ADDR_CONTROL_SECOND, 8'h00, "strobe readback");
      wr(0, ADDR_CONTROL_FIRST, 8'h72);
      wr(0, ADDR_COUNT_VALUE, 8'h10);
      wr(0, ADDR_COMPARE_A, 8'h10);
      wr(0, ADDR_CONTROL_SECOND, 8'h80);
      chk("pin a clear mode", 8'h00, {7'h00, wave_a});
      rd(0, ADDR_COUNT_VALUE, 8'h10, "count after force");
      rd(0, ADDR_EVENT_FLAGS, 8'h00, "forced flags");
      for (int m = 0; m < 4; m++) begin
         wr(0, ADDR_CONTROL_FIRST, {6'h1c, pwm[m][1:0]});
         wr(0, ADDR_CONTROL_SECOND, {4'h8, pwm[m][2], 3'h0});
         chk("pwm pin a", 8'h00, {7'h00, wave_a});
      end
      wr(0, ADDR_CONTROL_SECOND, 8'h00);
      wr(0, ADDR_CONTROL_FIRST, 8'h70);
      $display("test force done");
      wr(0, ADDR_COMPARE_A, 8'h03);
      wr(0, ADDR_COMPARE_B, 8'h05);
      wr(0, ADDR_COUNT_VALUE, 8'h00);
      global_irq_en = 1'b1;
      run(3'h1, 8);
      rd(0, ADDR_EVENT_FLAGS, 8'h06, "match flags");
      chk("match requests", 8'h06, {5'h00, irq_req});
      global_irq_en = 1'b0;
      repeat (2) @(posedge sys_clk);
      #1 chk("masked requests", 8'h00, {5'h00, irq_req});
      global_irq_en = 1'b1;
      wr(1, 8'h17, 8'h02);
      rd(1, 8'h17, 8'h04, "one clears a");
      vector_ack = 3'h4;
      @(posedge sys_clk);
      #1 vector_ack = 3'h0;
      rd(0, ADDR_EVENT_FLAGS, 8'h00, "vector clears b");
      wr(0, ADDR_COUNT_VALUE, 8'hfd);
      run(3'h1, 5);
      rd(0, ADDR_EVENT_FLAGS, 8'h01, "wrap flag");
      chk("wrap request", 8'h01, {5'h00, irq_req});
      wr(0, ADDR_EVENT_FLAGS, 8'h07);
      wr(0, ADDR_COMPARE_B, 8'h80);
      wr(0, ADDR_COUNT_VALUE, 8'h03);
      run(3'h1, 3);
      rd(0, ADDR_EVENT_FLAGS, 8'h00, "blocked match");
      $display("test flags done");
      wrap_up();
   end
   initial begin
      #200000;
      n_errors++;
      wrap_up();
   end
endmodule
bind tmr2_regs tmr2_regs_asserts u_chk (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
   .REG_RD(REG_RD), .REG_WR(REG_WR), .REG_IO_SPACE(REG_IO_SPACE), .REG_ADDR(REG_ADDR),
   .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN),
   .VECTOR_ACK(VECTOR_ACK), .IRQ_REQ(IRQ_REQ), .WAVE_OUT_A(WAVE_OUT_A),
   .WAVE_OUT_B(WAVE_OUT_B));
`default_nettype wire

//--- tb/tmr2_regs_asserts.sv
// Concurrent checks on the ports of the compare-timer register slice
`timescale 1ns/1ps
`default_nettype none
module tmr2_regs_asserts
   import tmr2_pkg::*;
(
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   // Register port
   input wire logic REG_RD,
   input wire logic REG_WR,
   input wire logic REG_IO_SPACE,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic [7:0] REG_RDATA,
   // Interrupts and pins
   input wire logic GLOBAL_IRQ_EN,
   input wire logic [2:0] VECTOR_ACK,
   input wire logic [2:0] IRQ_REQ,
   input wire logic WAVE_OUT_A,
   input wire logic WAVE_OUT_B
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RESET_N);
   logic rd_ctl;
   logic rd_flg;
   logic wr_pwm;
   assign rd_ctl = REG_RD && !REG_IO_SPACE && REG_ADDR == ADDR_CONTROL_SECOND;
   assign rd_flg = REG_RD && (REG_IO_SPACE ? REG_ADDR == 8'h17 : REG_ADDR == ADDR_EVENT_FLAGS);
   // Only valid while the counter was already stopped, as the bench arranges
   assign wr_pwm = REG_WR && !REG_IO_SPACE && REG_ADDR == ADDR_CONTROL_SECOND
      && REG_WDATA[BIT_WAVE_HIGH] && REG_WDATA[2:0] == 3'h0;
   rdata_idle_a: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
      else $error("read data without a read");
   force_rd_zero_a: assert property ($past(rd_ctl) |-> REG_RDATA[7:6] == 2'h0)
      else $error("strobe bits read back set");
   io_range_a: assert property ($past(REG_RD && REG_IO_SPACE && REG_ADDR > IO_SPACE_LAST)
      |-> REG_RDATA == 8'h00)
      else $error("short address beyond range answered");
   flag_rsvd_a: assert property ($past(rd_flg) |-> REG_RDATA[7:3] == 5'h00)
      else $error("flag register upper bits set");
   pwm_force_a: assert property (wr_pwm |=> $stable(WAVE_OUT_A) && $stable(WAVE_OUT_B))
      else $error("force acted in a pwm mode");
   irq_b_gate_a: assert property (IRQ_REQ[2] |-> $past(GLOBAL_IRQ_EN))
      else $error("match b request without global enable");
   irq_a_gate_a: assert property ($rose(IRQ_REQ[1]) |-> $past(GLOBAL_IRQ_EN))
      else $error("match a request without global enable");
   irq_w_gate_a: assert property (!$past(GLOBAL_IRQ_EN) |-> !IRQ_REQ[0])
      else $error("wrap request without global enable");
   reset_quiet_a: assert property ($rose(RESET_N) |-> IRQ_REQ == 3'h0 && !WAVE_OUT_A)
      else $error("outputs not cleared by reset");
   cover property (wr_pwm);
   cover property ($rose(IRQ_REQ[2]));
   cover property (rd_flg && REG_IO_SPACE);
endmodule
`default_nettype wire
